// [hdl/awr_pkg.sv]
package awr_pkg;
    // queue geometry
    localparam int DEPTH = 16;
    localparam int AW = 4;
    localparam int CW = AW + 2;
    localparam int EW = 6;
    localparam int RESP_W = 2;

    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_THRESH = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;
    localparam logic [7:0] ADDR_LEVEL = 8'h10;

    // field positions
    localparam int CTRL_FLUSH = 0;
    localparam int CTRL_INJ_S = 1;
    localparam int CTRL_INJ_D = 2;
    localparam int THR_FULL_POS = 0;
    localparam int THR_EMPTY_POS = 16;
    localparam int LVL_CNT_POS = 0;
    localparam int LVL_PFULL = 16;
    localparam int LVL_PEMPTY = 17;
    localparam int EV_OVF = 0;
    localparam int EV_UNF = 1;
    localparam int EV_SBE = 2;
    localparam int EV_DBE = 3;
    localparam int EV_W = 4;

    // reset values and full-queue count
    localparam logic [AW-1:0] FULL_THR_RST = 4'hC;
    localparam logic [AW-1:0] EMPTY_THR_RST = 4'h2;
    localparam logic [CW-1:0] DEPTH_CNT = 6'h10;

    // response words
    localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
    localparam logic [RESP_W-1:0] RESP_EXOKAY = 2'h1;
    localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
    localparam logic [RESP_W-1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic [RESP_W-1:0] data;
        logic sbe;
        logic dbe;
    } awr_dec_t;

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [CW-1:0] mem_cnt;
        logic [CW-1:0] cnt;
        logic out_v;
        logic [RESP_W-1:0] out_resp;
        logic in_rdy;
        logic ovf;
        logic unf;
        logic sbe;
        logic dbe;
        logic pfull;
        logic pempty;
        logic [AW-1:0] full_thr;
        logic [AW-1:0] empty_thr;
        logic [AW-1:0] reg_full_thr;
        logic [AW-1:0] reg_empty_thr;
        logic [2:0] ctrl;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic irq;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } awr_state_t;
endpackage : awr_pkg

// [hdl/awr_resp_fifo.sv]
// The address map and the APB register port were decided locally.
`timescale 1ns/10ps
// How it works
// (R1) two-bit response passes through unchanged
// (R2) upstream valid high while entry held, from two cycles after a write to an empty queue
// (R3) master ready gates consumption of entries
// (R4) slave valid offers one response word
// (R5) downstream ready high while queue has room and no flush is set
// (R6) full threshold loaded only during flush
// (R7) empty threshold loaded only during flush
// (R8) prog full when count at/above threshold
// (R9) prog empty when count at/below threshold
// (R10) single inject flips one stored bit
// (R11) double inject flips two stored bits
// (R12) corrected error flagged, repaired word delivered
// (R13) uncorrectable error flagged on double fault
// (R14) overflow one cycle after write refused while full
// (R15) underflow one cycle after refused read
// (R16) write count shows write next edge
// (R17) read count shows read next edge
// (R18) data count equals words stored
// (R19) strict first-in first-out order
module awr_resp_fifo #(
    parameter bit ECC_EN = 1'b1
) (
    // clock and reset
    input logic ref_clk_i,
    input logic reset_n_i,
    // apb slave
    input logic psel_i,
    input logic penable_i,
    input logic pwrite_i,
    input logic [7:0] paddr_i,
    input logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // downstream slave side
    input logic m_bvalid_i,
    input logic [awr_pkg::RESP_W-1:0] m_bresp_i,
    output logic m_bready_o,
    // upstream master side
    output logic s_bvalid_o,
    output logic [awr_pkg::RESP_W-1:0] s_bresp_o,
    input logic s_bready_i,
    // sideband status
    output logic prog_full_o,
    output logic prog_empty_o,
    output logic sbiterr_o,
    output logic dbiterr_o,
    output logic overflow_o,
    output logic underflow_o,
    output logic [awr_pkg::CW-1:0] wr_data_count_o,
    output logic [awr_pkg::CW-1:0] rd_data_count_o,
    output logic [awr_pkg::CW-1:0] data_count_o,
    output logic irq_o
);
    // secded over two data bits, bit 0 overall parity
    function automatic logic [awr_pkg::EW-1:0] awr_encode(input logic [1:0] d,
                                                        input logic inj_s,
                                                        input logic inj_d);
        logic [awr_pkg::EW-1:0] c;
        c = '0;
        c[1] = d[0] ^ d[1];
        c[2] = d[0];
        c[3] = d[0];
        c[4] = d[1];
        c[5] = d[1];
        c[0] = ^c[5:1];
        if (inj_d) begin
            c[3] = ~c[3]; // [R11]
            c[5] = ~c[5]; // [R11]
        end else if (inj_s) begin
            c[3] = ~c[3]; // [R10]
        end
        return c;
    endfunction : awr_encode

    function automatic awr_pkg::awr_dec_t awr_decode(input logic [awr_pkg::EW-1:0] c,
                                                     input logic ecc);
        awr_pkg::awr_dec_t r;
        logic [2:0] s;
        logic p;
        s = {c[4] ^ c[5], c[2] ^ c[3], c[1] ^ c[3] ^ c[5]};
        p = ^c;
        r.data = {c[5], c[3]}; // [R1]
        r.sbe = 1'b0;
        r.dbe = 1'b0;
        if (ecc) begin
            if (p) begin
                r.sbe = 1'b1; // [R12]
                if (s == 3'h3) begin
                    r.data[0] = ~c[3];
                end
                if (s == 3'h5) begin
                    r.data[1] = ~c[5];
                end
            end else if (s != 3'h0) begin
                r.dbe = 1'b1; // [R13]
            end
        end
        return r;
    endfunction : awr_decode

    logic [1:0] rst_sync_q;
    logic rst_n;
    awr_pkg::awr_state_t q;
    awr_pkg::awr_state_t n;
    logic [awr_pkg::EW-1:0] mem [awr_pkg::DEPTH];
    logic wr;
    logic pop;
    logic load;
    logic setup;
    logic acc;
    logic [awr_pkg::EV_W-1:0] ev;
    awr_pkg::awr_dec_t dec;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_comb begin
        n = q;
        wr = m_bvalid_i & q.in_rdy; // [R4] [R5]
        pop = q.out_v & s_bready_i; // [R3]
        load = (q.mem_cnt != '0) & (~q.out_v | pop);
        dec = awr_decode(mem[q.rd_ptr], ECC_EN);
        setup = psel_i & ~penable_i;
        acc = psel_i & penable_i & q.pready;
        ev = '0;
        ev[awr_pkg::EV_OVF] = m_bvalid_i & ~q.in_rdy & (q.cnt >= awr_pkg::DEPTH_CNT); // [R14]
        ev[awr_pkg::EV_UNF] = s_bready_i & ~q.out_v; // [R15]
        ev[awr_pkg::EV_SBE] = load & dec.sbe;
        ev[awr_pkg::EV_DBE] = load & dec.dbe;
        // queue pointers and counts
        if (wr) begin
            n.wr_ptr = q.wr_ptr + 1'b1;
        end
        if (load) begin
            n.rd_ptr = q.rd_ptr + 1'b1; // [R19]
            n.out_resp = dec.data; // [R1] [R12]
        end
        n.out_v = load | (q.out_v & ~pop); // [R2]
        n.mem_cnt = q.mem_cnt + awr_pkg::CW'(wr) - awr_pkg::CW'(load);
        n.cnt = q.cnt + awr_pkg::CW'(wr) - awr_pkg::CW'(pop); // [R16] [R17] [R18]
        n.ovf = ev[awr_pkg::EV_OVF];
        n.unf = ev[awr_pkg::EV_UNF];
        n.sbe = ev[awr_pkg::EV_SBE];
        n.dbe = ev[awr_pkg::EV_DBE];
        // apb access
        n.pready = setup;
        if (setup) begin
            n.pslverr = 1'b0;
            n.prdata = '0;
            case (paddr_i)
                awr_pkg::ADDR_CTRL: begin
                    n.prdata[2:0] = q.ctrl;
                end
                awr_pkg::ADDR_THRESH: begin
                    n.prdata[awr_pkg::THR_FULL_POS +: awr_pkg::AW] = q.reg_full_thr;
                    n.prdata[awr_pkg::THR_EMPTY_POS +: awr_pkg::AW] = q.reg_empty_thr;
                end
                awr_pkg::ADDR_STATUS: begin
                    n.prdata[awr_pkg::EV_W-1:0] = q.status;
                end
                awr_pkg::ADDR_MASK: begin
                    n.prdata[awr_pkg::EV_W-1:0] = q.mask;
                end
                awr_pkg::ADDR_LEVEL: begin
                    n.prdata[awr_pkg::LVL_CNT_POS +: awr_pkg::CW] = q.cnt;
                    n.prdata[awr_pkg::LVL_PFULL] = q.pfull;
                    n.prdata[awr_pkg::LVL_PEMPTY] = q.pempty;
                end
                default: begin
                    n.pslverr = 1'b1;
                end
            endcase
        end
        // read clears only what was reported, new events win
        if (acc && !pwrite_i && paddr_i == awr_pkg::ADDR_STATUS) begin
            n.status = q.status & ~q.prdata[awr_pkg::EV_W-1:0];
        end
        n.status = n.status | ev;
        if (acc && pwrite_i) begin
            case (paddr_i)
                awr_pkg::ADDR_CTRL: begin
                    n.ctrl = pwdata_i[2:0];
                end
                awr_pkg::ADDR_THRESH: begin
                    n.reg_full_thr = pwdata_i[awr_pkg::THR_FULL_POS +: awr_pkg::AW];
                    n.reg_empty_thr = pwdata_i[awr_pkg::THR_EMPTY_POS +: awr_pkg::AW];
                end
                awr_pkg::ADDR_MASK: begin
                    n.mask = pwdata_i[awr_pkg::EV_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // flush empties the queue and loads thresholds
        if (q.ctrl[awr_pkg::CTRL_FLUSH]) begin
            n.full_thr = q.reg_full_thr; // [R6]
            n.empty_thr = q.reg_empty_thr; // [R7]
            n.wr_ptr = '0;
            n.rd_ptr = '0;
            n.mem_cnt = '0;
            n.cnt = '0;
            n.out_v = 1'b0;
        end
        n.in_rdy = (n.cnt < awr_pkg::DEPTH_CNT) & ~n.ctrl[awr_pkg::CTRL_FLUSH]; // [R5]
        n.pfull = n.cnt >= awr_pkg::CW'(n.full_thr); // [R8]
        n.pempty = n.cnt <= awr_pkg::CW'(n.empty_thr); // [R9]
        n.irq = |(n.status & n.mask);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.full_thr <= awr_pkg::FULL_THR_RST;
            q.empty_thr <= awr_pkg::EMPTY_THR_RST;
            q.reg_full_thr <= awr_pkg::FULL_THR_RST;
            q.reg_empty_thr <= awr_pkg::EMPTY_THR_RST;
            q.pempty <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // storage array, no reset needed
    always_ff @(posedge ref_clk_i) begin
        if (wr) begin
            mem[q.wr_ptr] <= awr_encode(m_bresp_i, q.ctrl[awr_pkg::CTRL_INJ_S] & ECC_EN,
                                        q.ctrl[awr_pkg::CTRL_INJ_D] & ECC_EN); // [R10] [R11]
        end
    end

    assign pready_o = q.pready;
    assign prdata_o = q.prdata;
    assign pslverr_o = q.pslverr;
    assign m_bready_o = q.in_rdy;
    assign s_bvalid_o = q.out_v;
    assign s_bresp_o = q.out_resp;
    assign prog_full_o = q.pfull;
    assign prog_empty_o = q.pempty;
    assign sbiterr_o = q.sbe;
    assign dbiterr_o = q.dbe;
    assign overflow_o = q.ovf;
    assign underflow_o = q.unf;
    assign wr_data_count_o = q.cnt;
    assign rd_data_count_o = q.cnt;
    assign data_count_o = q.cnt;
    assign irq_o = q.irq;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_inj_single;
        ECC_EN && wr && q.ctrl[awr_pkg::CTRL_INJ_S] && !q.ctrl[awr_pkg::CTRL_INJ_D] && q.cnt == '0;
    endsequence
    sequence s_inj_double;
        ECC_EN && wr && q.ctrl[awr_pkg::CTRL_INJ_D] && q.cnt == '0;
    endsequence

    property p_r2_valid;
        (q.cnt != '0 && !s_bvalid_o && !q.ctrl[0]) |=> s_bvalid_o;
    endproperty
    a_r2_valid: assert property (p_r2_valid) else $error("valid late"); // [R2]
    property p_r5_ready;
        m_bready_o |-> data_count_o < awr_pkg::DEPTH_CNT;
    endproperty
    a_r5_ready: assert property (p_r5_ready) else $error("ready while full"); // [R5]
    property p_r6_thr;
        !q.ctrl[awr_pkg::CTRL_FLUSH] |=> $stable(q.full_thr) && $stable(q.empty_thr);
    endproperty
    a_r6_thr: assert property (p_r6_thr) else $error("threshold moved"); // [R6] [R7]
    property p_r8_full;
        prog_full_o == (data_count_o >= awr_pkg::CW'(q.full_thr));
    endproperty
    a_r8_full: assert property (p_r8_full) else $error("prog full wrong"); // [R8]
    property p_r9_empty;
        prog_empty_o == (data_count_o <= awr_pkg::CW'(q.empty_thr));
    endproperty
    a_r9_empty: assert property (p_r9_empty) else $error("prog empty wrong"); // [R9]
    property p_r10_single;
        s_inj_single |-> ##[1:3] (sbiterr_o && !dbiterr_o);
    endproperty
    a_r10_single: assert property (p_r10_single) else $error("no sbit"); // [R10] [R12]
    property p_r11_double;
        s_inj_double |-> ##[1:3] dbiterr_o;
    endproperty
    a_r11_double: assert property (p_r11_double) else $error("no dbit"); // [R11] [R13]
    property p_r14_ovf;
        (m_bvalid_i && !m_bready_o && data_count_o == awr_pkg::DEPTH_CNT) |=> overflow_o;
    endproperty
    a_r14_ovf: assert property (p_r14_ovf) else $error("overflow missed"); // [R14]
    property p_r15_unf;
        (s_bready_i && !s_bvalid_o) |=> underflow_o;
    endproperty
    a_r15_unf: assert property (p_r15_unf) else $error("underflow missed"); // [R15]
    property p_r16_count;
        (wr && !pop && !q.ctrl[0]) |=> data_count_o == $past(data_count_o) + 1'b1;
    endproperty
    a_r16_count: assert property (p_r16_count) else $error("count lost write"); // [R16] [R18]
    property p_r17_count;
        (pop && !wr && !q.ctrl[0]) |=> rd_data_count_o == $past(rd_data_count_o) - 1'b1;
    endproperty
    a_r17_count: assert property (p_r17_count) else $error("count lost read"); // [R17]
    property p_r19_hold;
        (s_bvalid_o && !s_bready_i && !q.ctrl[0]) |=> s_bvalid_o && $stable(s_bresp_o);
    endproperty
    a_r19_hold: assert property (p_r19_hold) else $error("response dropped"); // [R19]
endmodule : awr_resp_fifo

// [verif/awr_link_model.sv]
`timescale 1ns/10ps
module awr_link_model (
    // clock
    input logic ref_clk_i,
    // downstream slave side
    input logic m_bready_i,
    output logic m_bvalid_o,
    output logic [awr_pkg::RESP_W-1:0] m_bresp_o,
    // upstream master side
    input logic [1:0] rdy_mode_i,
    output logic s_bready_o
);
    int seed = 32'h5743;

    initial begin
        m_bvalid_o = 1'b0;
        m_bresp_o = 2'h0;
        s_bready_o = 1'b0;
    end

    // ready: never, always or random
    always @(posedge ref_clk_i) begin
        case (rdy_mode_i)
            2'h0: s_bready_o <= 1'b0;
            2'h1: s_bready_o <= 1'b1;
            default: s_bready_o <= 1'($random(seed));
        endcase
    end

    // back-to-back words, each held until taken or max cycles pass
    task automatic send(input int words, input int max, output int taken);
        int n;
        taken = 0;
        @(posedge ref_clk_i);
        for (int w = 0; w < words; w++) begin
            m_bvalid_o <= 1'b1;
            m_bresp_o <= 2'($random(seed));
            n = 0;
            do begin
                @(posedge ref_clk_i);
                n++;
            end while (m_bready_i !== 1'b1 && n < max);
            if (m_bready_i === 1'b1) taken++;
        end
        m_bvalid_o <= 1'b0;
        m_bresp_o <= ~m_bresp_o;
    endtask : send
endmodule : awr_link_model

// [verif/awr_resp_fifo_bench.sv]
`timescale 1ns/10ps
module awr_resp_fifo_bench;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic m_bvalid, m_bready, s_bvalid, s_bready, pfull, pempty, sbe, dbe, ovf, unf, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] m_bresp, s_bresp, rdy_mode;
    logic [5:0] wrc, rdc, dc;
    int fail_count = 0;
    int check_count = 0;
    int cnt = 0;
    int prev_cnt = -1;
    int sbe_n = 0;
    int dbe_n = 0;
    int taken;
    logic [1:0] q[$];
    logic chk_en = 1'b0;
    logic data_chk = 1'b1;
    logic ovf_x = 1'b0;
    logic unf_x = 1'b0;
    logic [3:0] thr_f = awr_pkg::FULL_THR_RST;
    logic [3:0] thr_e = awr_pkg::EMPTY_THR_RST;

    awr_resp_fifo dut_u (.ref_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .m_bvalid_i(m_bvalid),
        .m_bresp_i(m_bresp), .m_bready_o(m_bready), .s_bvalid_o(s_bvalid),
        .s_bresp_o(s_bresp), .s_bready_i(s_bready), .prog_full_o(pfull),
        .prog_empty_o(pempty), .sbiterr_o(sbe), .dbiterr_o(dbe), .overflow_o(ovf),
        .underflow_o(unf), .wr_data_count_o(wrc), .rd_data_count_o(rdc),
        .data_count_o(dc), .irq_o(irq));
    awr_link_model p_u (.ref_clk_i(clk), .m_bready_i(m_bready), .m_bvalid_o(m_bvalid),
        .m_bresp_o(m_bresp), .rdy_mode_i(rdy_mode), .s_bready_o(s_bready));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // level register word for a given count and thresholds
    function automatic logic [31:0] exp_level(input int c, input logic [3:0] f,
                                              input logic [3:0] e);
        logic [31:0] v;
        v = 32'h0;
        v[awr_pkg::LVL_CNT_POS +: awr_pkg::CW] = awr_pkg::CW'(c);
        v[awr_pkg::LVL_PFULL] = c >= f;
        v[awr_pkg::LVL_PEMPTY] = c <= e;
        return v;
    endfunction : exp_level

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task automatic timeout();
        fail_count++;
        $display("[FAIL] %0t wait timed out", $time);
        end_of_test();
    endtask : timeout

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) timeout();
    endtask : apb

    task automatic drain();
        int n;
        n = 0;
        rdy_mode <= 2'h1;
        while ((cnt != 0 || s_bvalid !== 1'b0) && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) timeout();
        rdy_mode <= 2'h0;
        repeat (3) @(posedge clk);
    endtask : drain

    // flush while loading thresholds, then restart the reference queue
    task automatic load_thr(input logic [3:0] f, input logic [3:0] e);
        chk_en = 1'b0;
        apb(1'b1, awr_pkg::ADDR_CTRL, 32'h1);
        apb(1'b1, awr_pkg::ADDR_THRESH, {12'h0, e, 12'h0, f});
        apb(1'b1, awr_pkg::ADDR_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        q.delete();
        cnt = 0;
        prev_cnt = -1;
        thr_f = f;
        thr_e = e;
        chk_en = 1'b1;
    endtask : load_thr

    always @(posedge clk) begin
        ovf_x <= m_bvalid === 1'b1 && m_bready === 1'b0 && cnt == 16;
        unf_x <= s_bready === 1'b1 && s_bvalid === 1'b0;
        if (sbe === 1'b1) sbe_n++;
        if (dbe === 1'b1) dbe_n++;
        if (m_bvalid === 1'b1 && m_bready === 1'b1) begin
            q.push_back(m_bresp);
            cnt++;
        end
        if (s_bvalid === 1'b1 && s_bready === 1'b1) begin
            if (data_chk && chk_en) chk(32'(s_bresp), 32'(q[0]));
            void'(q.pop_front());
            cnt--;
        end
    end

    always @(negedge clk) begin
        if (chk_en) begin
            chk(32'(dc), cnt);
            chk(32'(wrc), cnt);
            chk(32'(rdc), cnt);
            chk(32'(m_bready), 32'(cnt < 16));
            chk(32'(s_bvalid === 1'b1 && cnt == 0), 32'h0);
            chk(32'(ovf), 32'(ovf_x));
            chk(32'(unf), 32'(unf_x));
            if (cnt == prev_cnt) begin
                chk(32'(pfull), 32'(cnt >= thr_f));
                chk(32'(pempty), 32'(cnt <= thr_e));
            end
            prev_cnt = cnt;
        end
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rdy_mode = 2'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk_en = 1'b1;
        apb(1'b0, awr_pkg::ADDR_THRESH, 32'h0);
        chk(rd, {12'h0, thr_e, 12'h0, thr_f});
        apb(1'b0, awr_pkg::ADDR_MASK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        // threshold write outside flush must not take effect
        apb(1'b1, awr_pkg::ADDR_THRESH, 32'h0006_0009);
        rdy_mode <= 2'h2;
        p_u.send(40, 60, taken);
        chk(taken, 40);
        drain();
        load_thr(4'h5, 4'h3);
        p_u.send(16, 60, taken);
        chk(taken, 16);
        p_u.send(1, 4, taken);
        chk(taken, 0);
        apb(1'b0, awr_pkg::ADDR_LEVEL, 32'h0);
        chk(rd, exp_level(16, thr_f, thr_e));
        drain();
        // interrupt raised, masked and cleared
        apb(1'b1, awr_pkg::ADDR_MASK, 32'h1 << awr_pkg::EV_UNF);
        apb(1'b0, awr_pkg::ADDR_STATUS, 32'h0);
        apb(1'b0, awr_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h0);
        chk(32'(irq), 32'h0);
        rdy_mode <= 2'h1;
        repeat (3) @(posedge clk);
        rdy_mode <= 2'h0;
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h1);
        apb(1'b1, awr_pkg::ADDR_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        apb(1'b0, awr_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h1 << awr_pkg::EV_UNF);
        // error injection, single then double
        apb(1'b1, awr_pkg::ADDR_CTRL, 32'h1 << awr_pkg::CTRL_INJ_S);
        sbe_n = 0;
        p_u.send(3, 60, taken);
        apb(1'b1, awr_pkg::ADDR_CTRL, 32'h0);
        drain();
        chk(sbe_n, 3);
        chk(dbe_n, 0);
        apb(1'b0, awr_pkg::ADDR_STATUS, 32'h0);
        chk(32'(rd[awr_pkg::EV_SBE]), 32'h1);
        data_chk = 1'b0;
        apb(1'b1, awr_pkg::ADDR_CTRL, 32'h1 << awr_pkg::CTRL_INJ_D);
        dbe_n = 0;
        p_u.send(2, 60, taken);
        apb(1'b1, awr_pkg::ADDR_CTRL, 32'h0);
        drain();
        chk(dbe_n, 2);
        apb(1'b0, awr_pkg::ADDR_STATUS, 32'h0);
        chk(32'(rd[awr_pkg::EV_DBE]), 32'h1);
        end_of_test();
    end
endmodule : awr_resp_fifo_bench
